// ---- pg_power_ctrl.sv ----
// Power-gating control of the programmable logic and memory module
// ------------------------------------------------------------
// What this block does
// [RL1] Chip select input function is off by default
// [RL2] Select low lets memory selects decode
// [RL3] Select high suppresses every memory select
// [RL4] Select high leaves logic and pins alone
// [RL5] Mode bit three turns fast mode off
// [RL6] Quiet inputs in low-power mode mean standby
// [RL7] Fast mode bit resets to zero
// [RL8] Processor adds wait state when fast off; this block does not stretch the bus
// [RL9] Unblocked strobe edge wakes arrays from standby
// [RL10] Mode-two bits two-five block bus strobes
// [RL11] Blocked strobes still reach the memories
// [RL12] Firmware may unblock strobes around peripheral access
// [RL13] Mode-two bit six blocks port C pin seven
// [RL14] Common clock feeds macrocells, array bus, counter
// [RL15] Mode bit four blocks clock from array bus
// [RL16] Mode bit five blocks clock from macrocells
// [RL17] Written bits act from the next cycle
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module pg_power_ctrl
  import pg_pkg::*;
#(
  parameter bit LOW_VOLT = 1'b0  // Set for 3.3 V parts (longer idle interval)
)
(
  input  wire logic        clk,                    // 125 MHz system clock
  input  wire logic        srst,                   // Synchronous reset, active high
  // Avalon-MM slave
  input  wire logic [4:0]  address,                // Byte address
  input  wire logic        read,                   // Read request
  input  wire logic        write,                  // Write request
  input  wire logic [31:0] writedata,              // Write data
  input  wire logic [3:0]  byteenable,             // Byte lanes
  output var  logic [31:0] readdata,               // Read data
  output var  logic        waitrequest,            // Low when answered
  // Pins
  input  wire logic        port_d_pin_two,         // Chip select input, active low
  input  wire logic        rd_n,                   // Processor read strobe
  input  wire logic        wr_n,                   // Processor write strobe
  input  wire logic        program_fetch_strobe_n, // Processor fetch strobe
  input  wire logic        ale,                    // Address latch strobe
  input  wire logic        port_c_pin_seven,       // General input pin
  input  wire logic        common_clock_input,     // Slow common clock pin
  // Select requests from the address decoder
  input  wire logic [3:0]  sel_req,                // Main, secondary, sram, ctrl
  // Gated outputs
  output var  logic        main_flash_select,      // Main flash selected
  output var  logic        secondary_flash_select, // Secondary flash selected
  output var  logic        sram_select,            // SRAM selected
  output var  logic        ctrl_reg_select,        // Control registers selected
  output var  logic [5:0]  array_in_bus,           // Strobes/pin/clock to arrays
  output var  logic [3:0]  mem_strobes,            // Strobes to memories
  output var  logic        macrocell_clk,          // Clock to macrocell flops
  output var  logic        powerdown_clk,          // Clock to power-down counter
  output var  logic        array_standby           // Arrays in standby
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       pm0;    // power_mode_reg_zero
    logic [7:0]       pm2;    // power_mode_reg_two
    logic             csi_en; // Pin acts as chip select
    logic             wt;     // waitrequest
    logic [31:0]      rdat;   // Read data
    logic [NPINS-1:0] s1;     // First synchroniser stage
    logic [NPINS-1:0] s2;     // Second synchroniser stage
    logic [3:0]       sel;    // Gated memory selects
    logic [5:0]       bus;    // Array input bus
    logic [3:0]       mstb;   // Memory strobes
    logic             mcclk;  // Macrocell clock
    logic             pdclk;  // Power-down counter clock
  } ctl_s;

  ctl_s st_r;    // Registered state
  ctl_s st_nxt;  // Next state
  logic standby; // From the idle timer
  logic active;  // Array inputs changed
  logic take;    // Bus request accepted this edge
  logic sel_ok;  // Memory selects permitted

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    take   = (read || write) && !st_r.wt;

    // Pins are asynchronous; s1 is read only by s2
    st_nxt.s1 = {common_clock_input, port_c_pin_seven, ale,
                 program_fetch_strobe_n, wr_n, rd_n, port_d_pin_two};
    st_nxt.s2 = st_r.s1;

    // Bus answer: waitrequest falls one cycle after the request appears
    if (take)
      st_nxt.wt = 1'b1;
    else if (read || write)
      st_nxt.wt = 1'b0;
    else
      st_nxt.wt = 1'b1;

    // Read data is prepared with the answer, unmapped reads give zero
    st_nxt.rdat = 32'h0000_0000;
    if (read && st_r.wt)
    begin
      unique case (address)
        OFS_PMODE0: st_nxt.rdat = {24'h000000, st_r.pm0};
        OFS_PMODE2: st_nxt.rdat = {24'h000000, st_r.pm2};
        OFS_CONFIG: st_nxt.rdat = {31'h00000000, st_r.csi_en};
        OFS_STATUS: st_nxt.rdat = {29'h00000000, sel_ok,
                                   st_r.s2[PIN_CSI], standby};
        default:    st_nxt.rdat = 32'h0000_0000;
      endcase
    end

    // Writes land at the accepting edge; unmapped writes are dropped
    if (take && write && byteenable[0])
    begin
      unique case (address)
        OFS_PMODE0: st_nxt.pm0    = writedata[7:0];      // RL5 RL17
        OFS_PMODE2: st_nxt.pm2    = writedata[7:0];      // RL17
        OFS_CONFIG: st_nxt.csi_en = writedata[CFG_CSI_EN]; // RL1
        default:    st_nxt.pm0    = st_r.pm0;
      endcase
    end

    // Selects pass only while the chip select is low or unused
    st_nxt.sel = sel_ok ? sel_req : 4'h0; // RL2 RL3

    // Array input bus: a blocked input sits at its idle level
    st_nxt.bus[0] = st_r.pm2[PM2_BLK_RD]  ? BUS_IDLE[0] : st_r.s2[PIN_RD];  // RL10
    st_nxt.bus[1] = st_r.pm2[PM2_BLK_WR]  ? BUS_IDLE[1] : st_r.s2[PIN_WR];  // RL10
    st_nxt.bus[2] = st_r.pm2[PM2_BLK_PF]  ? BUS_IDLE[2] : st_r.s2[PIN_PF];  // RL10
    st_nxt.bus[3] = st_r.pm2[PM2_BLK_ALE] ? BUS_IDLE[3] : st_r.s2[PIN_ALE]; // RL10
    st_nxt.bus[4] = st_r.pm2[PM2_BLK_PC7] ? BUS_IDLE[4] : st_r.s2[PIN_PC7]; // RL13
    st_nxt.bus[5] = st_r.pm0[PM0_BLK_BUS] ? BUS_IDLE[5] : st_r.s2[PIN_CLK]; // RL14 RL15

    // Memories always see the strobes, blocked or not
    st_nxt.mstb = {st_r.s2[PIN_ALE], st_r.s2[PIN_PF],
                   st_r.s2[PIN_WR], st_r.s2[PIN_RD]}; // RL11

    // Common clock fan-out; the counter copy is never gated
    st_nxt.mcclk = st_r.s2[PIN_CLK] && !st_r.pm0[PM0_BLK_MC]; // RL14 RL16
    st_nxt.pdclk = st_r.s2[PIN_CLK];                          // RL14 RL15
  end

  // Chip select only matters once enabled; logic and pins are untouched
  assign sel_ok = !st_r.csi_en || !st_r.s2[PIN_CSI]; // RL1 RL4
  // Any change on the unblocked bus wakes the arrays
  assign active = st_nxt.bus != st_r.bus; // RL9

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r        <= '0;
      st_r.pm0    <= PMODE0_RST; // RL7
      st_r.pm2    <= PMODE2_RST;
      st_r.csi_en <= CSI_EN_RST;
      st_r.wt     <= 1'b1;
      st_r.s1     <= '1;
      st_r.s2     <= '1;
      st_r.bus    <= BUS_IDLE;
      st_r.mstb   <= 4'hF;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Idle timer
  // ------------------------------------------------------------
  // The processor must add a bus wait state itself when fast mode is off
  // (RL8); this block only slows the arrays, it does not stretch the bus.
  pg_idle_timer #(
    .IDLE_CYC (LOW_VOLT ? 4'(IDLE_CYC_3V3) : 4'(IDLE_CYC_5V))
  ) u_idle (
    .clk       (clk),
    .srst      (srst),
    .fast_off  (st_r.pm0[PM0_FAST_OFF]),
    .activity  (active),
    .standby_r (standby)
  );

  // ------------------------------------------------------------
  // Outputs straight from flops
  // ------------------------------------------------------------
  assign readdata               = st_r.rdat;
  assign waitrequest            = st_r.wt;
  assign main_flash_select      = st_r.sel[0];
  assign secondary_flash_select = st_r.sel[1];
  assign sram_select            = st_r.sel[2];
  assign ctrl_reg_select        = st_r.sel[3];
  assign array_in_bus           = st_r.bus;
  assign mem_strobes            = st_r.mstb;
  assign macrocell_clk          = st_r.mcclk;
  assign powerdown_clk          = st_r.pdclk;
  assign array_standby          = standby;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_fast_reset;
    $fell(srst) |-> !st_r.pm0[PM0_FAST_OFF] && !st_r.csi_en;
  endproperty
  a_fast_reset: assert property (@(posedge clk) p_fast_reset) else $error("bad reset"); // RL7

  property p_csi_block;
    st_r.csi_en && st_r.s2[PIN_CSI] |=> st_r.sel == 4'h0;
  endproperty
  a_csi_block: assert property (p_csi_block) else $error("select not suppressed"); // RL3

  // Chip select high must not freeze the array inputs
  property p_csi_keep;
    st_r.csi_en && st_r.s2[PIN_CSI] && !st_r.pm2[PM2_BLK_PC7]
      |=> st_r.bus[4] == $past(st_r.s2[PIN_PC7]);
  endproperty
  a_csi_keep: assert property (p_csi_keep) else $error("chip select froze logic"); // RL4

  property p_csi_pass;
    sel_ok |=> st_r.sel == $past(sel_req);
  endproperty
  a_csi_pass: assert property (p_csi_pass) else $error("select not passed"); // RL2

  property p_csi_unused;
    !st_r.csi_en |=> st_r.sel == $past(sel_req);
  endproperty
  a_csi_unused: assert property (p_csi_unused) else $error("selects gated"); // RL1

  // One check per blocking bit: firmware sets them singly, not only in pairs
  property p_rd_block;
    st_r.pm2[PM2_BLK_RD] |=> st_r.bus[0] == BUS_IDLE[0];
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("read strobe leaked"); // RL10

  property p_wr_block;
    st_r.pm2[PM2_BLK_WR] |=> st_r.bus[1] == BUS_IDLE[1];
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write strobe leaked"); // RL10

  property p_pf_block;
    st_r.pm2[PM2_BLK_PF] |=> st_r.bus[2] == BUS_IDLE[2];
  endproperty
  a_pf_block: assert property (p_pf_block) else $error("fetch strobe leaked"); // RL10

  property p_ale_block;
    st_r.pm2[PM2_BLK_ALE] |=> st_r.bus[3] == BUS_IDLE[3];
  endproperty
  a_ale_block: assert property (p_ale_block) else $error("latch strobe leaked"); // RL10

  property p_mem_strobe;
    1'b1 |=> st_r.mstb[0] == $past(st_r.s2[PIN_RD]);
  endproperty
  a_mem_strobe: assert property (p_mem_strobe) else $error("memory strobe gated"); // RL11

  property p_pc7_block;
    st_r.pm2[PM2_BLK_PC7] |=> st_r.bus[4] == BUS_IDLE[4];
  endproperty
  a_pc7_block: assert property (p_pc7_block) else $error("pin leaked"); // RL13

  property p_mc_block;
    st_r.pm0[PM0_BLK_MC] |=> !st_r.mcclk && st_r.pdclk == $past(st_r.s2[PIN_CLK]);
  endproperty
  a_mc_block: assert property (p_mc_block) else $error("macrocell clock gating"); // RL16

  // The counter copy of the clock is never gated by any bit
  property p_pd_clk;
    1'b1 |=> st_r.pdclk == $past(st_r.s2[PIN_CLK]);
  endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("counter clock gated"); // RL14 RL15

  property p_bus_clk_block;
    st_r.pm0[PM0_BLK_BUS] && !st_r.pm0[PM0_BLK_MC]
      |=> !st_r.bus[5] && st_r.mcclk == $past(st_r.s2[PIN_CLK]);
  endproperty
  a_bus_clk_block: assert property (p_bus_clk_block) else $error("bus clock gating"); // RL15

  property p_write_effect;
    write && !st_r.wt && byteenable[0] && address == OFS_PMODE0
      |=> st_r.pm0 == $past(writedata[7:0]);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("write lost"); // RL17

  property p_answer;
    (read || write) && st_r.wt |=> !st_r.wt;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");

  c_write: cover property (write && !st_r.wt);
  c_csi_off: cover property (st_r.csi_en && st_r.s2[PIN_CSI] && sel_req != 4'h0);
  c_lowpow: cover property (st_r.pm0[PM0_FAST_OFF] && standby);
  c_wake: cover property (standby ##1 !standby);

endmodule

`default_nettype wire

// ---- pg_pkg.sv ----
// Constants shared by the power-gating control block
package pg_pkg;

  // ------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_PMODE0 = 5'h00;  // power_mode_reg_zero
  localparam logic [4:0] OFS_PMODE2 = 5'h04;  // power_mode_reg_two
  localparam logic [4:0] OFS_CONFIG = 5'h08;  // Chip select input enable
  localparam logic [4:0] OFS_STATUS = 5'h0C;  // Read-only block state

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned PM0_FAST_OFF = 3;   // 1 = low-power array mode
  localparam int unsigned PM0_BLK_BUS  = 4;   // Clock off the array input bus
  localparam int unsigned PM0_BLK_MC   = 5;   // Clock off the macrocell flops
  localparam int unsigned PM2_BLK_RD   = 2;   // Read strobe blocked
  localparam int unsigned PM2_BLK_WR   = 3;   // Write strobe blocked
  localparam int unsigned PM2_BLK_PF   = 4;   // Program fetch strobe blocked
  localparam int unsigned PM2_BLK_ALE  = 5;   // Address latch strobe blocked
  localparam int unsigned PM2_BLK_PC7  = 6;   // Port C pin 7 blocked
  localparam int unsigned CFG_CSI_EN   = 0;   // Pin acts as chip select input
  localparam int unsigned ST_STANDBY   = 0;   // Arrays are in standby
  localparam int unsigned ST_CSI_LVL   = 1;   // Synchronised chip select level
  localparam int unsigned ST_SEL_OPEN  = 2;   // Memory selects are allowed

  // Pin vector positions in the synchroniser
  localparam int unsigned PIN_CSI = 0;
  localparam int unsigned PIN_RD  = 1;
  localparam int unsigned PIN_WR  = 2;
  localparam int unsigned PIN_PF  = 3;
  localparam int unsigned PIN_ALE = 4;
  localparam int unsigned PIN_PC7 = 5;
  localparam int unsigned PIN_CLK = 6;
  localparam int unsigned NPINS   = 7;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] PMODE0_RST = 8'h00;
  localparam logic [7:0] PMODE2_RST = 8'h00;
  localparam logic       CSI_EN_RST = 1'b0;
  // Array input bus order: clk, pc7, ale, pf_n, wr_n, rd_n; idle levels
  localparam logic [5:0] BUS_IDLE   = 6'h0F;

  // ------------------------------------------------------------
  // Timing: array idle interval before standby
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned IDLE_NS_5V   = 65;
  localparam int unsigned IDLE_NS_3V3  = 100;
  // Least times round up to whole cycles
  localparam int unsigned IDLE_CYC_5V  = (IDLE_NS_5V * CLK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_CYC_3V3 = (IDLE_NS_3V3 * CLK_MHZ + 999) / 1000;

endpackage

// ---- pg_idle_timer.sv ----
// Idle timer that puts the logic arrays into standby in low-power mode
`timescale 1ns/1ns
`default_nettype none

module pg_idle_timer
  import pg_pkg::*;
#(
  parameter logic [3:0] IDLE_CYC = 4'(IDLE_CYC_5V)  // Idle cycles before standby
)
(
  input  wire logic clk,       // System clock
  input  wire logic srst,      // Synchronous reset, active high
  input  wire logic fast_off,  // Low-power array mode selected
  input  wire logic activity,  // Any unblocked array input changed
  output var  logic standby_r  // Arrays latched and in standby
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;  // Quiet cycles seen
    logic       sb;   // Standby flag
  } tmr_s;

  tmr_s st_r;   // Registered state
  tmr_s st_nxt; // Next state

  // Count quiet cycles; any unblocked input edge wakes the arrays at once
  always_comb
  begin
    st_nxt = st_r;
    if (!fast_off || activity)
    begin
      // Fast mode never idles; an edge restarts the interval
      st_nxt.cnt = 4'h0; // RL9
      st_nxt.sb  = 1'b0; // RL9
    end
    else if (st_r.cnt >= IDLE_CYC - 4'h1)
    begin
      st_nxt.sb = 1'b1; // RL6
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // Register the state
  always_ff @(posedge clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign standby_r = st_r.sb;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_wake;
    activity |=> !standby_r;
  endproperty
  a_wake: assert property (p_wake) else $error("edge did not wake arrays"); // RL9

  property p_fast_no_sb;
    !fast_off |=> !standby_r;
  endproperty
  a_fast_no_sb: assert property (p_fast_no_sb) else $error("standby in fast mode"); // RL6

  property p_sb_needs_quiet;
    $rose(standby_r) |-> $past(!activity) && $past(fast_off);
  endproperty
  a_sb_needs_quiet: assert property (p_sb_needs_quiet) else $error("standby too early"); // RL6

  c_standby: cover property ($rose(standby_r));

endmodule

`default_nettype wire

// ---- pg_far_side.sv ----
// Far-side model: processor bus strobes, port pins, common clock and chip select driver
`timescale 1ns/1ns
`default_nettype none

module pg_far_side
(
  input  wire logic       clk,        // System clock
  input  wire logic       cs_cmd,     // Chip select level to present
  input  wire logic [3:0] strb_cmd,   // {ale, fetch_n, wr_n, rd_n} to present
  input  wire logic       pc7_cmd,    // Port C pin seven level
  input  wire logic       ck_cmd,     // Common clock level when not running
  input  wire logic       ck_run,     // Let the slow clock toggle
  output var  logic       cs_pin_n,   // Chip select input pin, active low
  output var  logic       rd_pin_n,   // Read strobe
  output var  logic       wr_pin_n,   // Write strobe
  output var  logic       pf_pin_n,   // Fetch strobe
  output var  logic       ale_pin,    // Address latch strobe
  output var  logic       pc7_pin,    // General pin
  output var  logic       ck_pin      // Common clock pin
);
  logic [1:0] div_r;  // Slow clock divider, the pin is far slower than clk

  // ----------------------------------------------------------
  // Pin drivers: the external device always drives its pins
  // ----------------------------------------------------------
  // Plain always: the divider and clock pin also get start values below
  always @(posedge clk)
  begin
    div_r    <= div_r + 2'h1;
    cs_pin_n <= cs_cmd;
    {ale_pin, pf_pin_n, wr_pin_n, rd_pin_n} <= strb_cmd;
    pc7_pin  <= pc7_cmd;
    // Free-running only on request, so quiet periods stay quiet
    if (ck_run && div_r == 2'h3)
      ck_pin <= ~ck_pin;
    else if (!ck_run)
      ck_pin <= ck_cmd;
  end

  initial
  begin
    div_r = 2'h0;
    ck_pin = 1'b0;
  end
endmodule

`default_nettype wire

// ---- pg_power_ctrl_bench.sv ----
// Self-checking bench for the power-gating control block
`timescale 1ns/1ns
`default_nettype none

module pg_power_ctrl_bench;
  import pg_pkg::*;

  logic        clk, srst, read, write, ck_run;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rv;
  logic        waitrequest, csn, rdn, wrn, pfn, ale, pc7, ck;
  logic        cs_cmd, pc7_cmd, ck_cmd;
  logic [3:0]  strb_cmd, sel_req;
  logic        m_sel, s_sel, r_sel, c_sel, mc_clk, pd_clk, stby;
  logic [5:0]  bus;
  logic [3:0]  mstr, msk, exp4;
  logic [7:0]  pm0_v [3];
  logic [2:0]  clk_exp [3];
  int          fail_count, cmp_count, i;

  // ----------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  pg_far_side far (.clk(clk), .cs_cmd(cs_cmd), .strb_cmd(strb_cmd), .pc7_cmd(pc7_cmd),
    .ck_cmd(ck_cmd), .ck_run(ck_run), .cs_pin_n(csn), .rd_pin_n(rdn), .wr_pin_n(wrn),
    .pf_pin_n(pfn), .ale_pin(ale), .pc7_pin(pc7), .ck_pin(ck));

  pg_power_ctrl dut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .port_d_pin_two(csn), .rd_n(rdn), .wr_n(wrn),
    .program_fetch_strobe_n(pfn), .ale(ale), .port_c_pin_seven(pc7),
    .common_clock_input(ck), .sel_req(sel_req), .main_flash_select(m_sel),
    .secondary_flash_select(s_sel), .sram_select(r_sel), .ctrl_reg_select(c_sel),
    .array_in_bus(bus), .mem_strobes(mstr), .macrocell_clk(mc_clk),
    .powerdown_clk(pd_clk), .array_standby(stby));

  // ----------------------------------------------------------
  // Verdict, compare and bus tasks
  // ----------------------------------------------------------
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is seen low at an edge
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    rd = 32'h0;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    // Up to 50 edges of wait states are absorbed; waitrequest low or the bound ends the wait
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
    begin
      fail_count++;
      wrap_up();
    end
    else
    begin
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Waits a bounded time for standby to reach the wanted level, returns the level seen
  task automatic wait_stby(input logic want, output logic got);
    int n;
    n = 0;
    while (stby !== want && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    got = stby;
    if (n >= 40)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  logic sb;
  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    sel_req = 4'hF;
    cs_cmd = 1'b1;
    strb_cmd = 4'h7;
    pc7_cmd = 1'b1;
    ck_cmd = 1'b0;
    ck_run = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped place reads zero
    av(1'b0, OFS_PMODE0, 32'h0, rv); chk(rv, 32'h0);
    settle(1); chk(waitrequest, 1'b1);
    av(1'b0, OFS_PMODE2, 32'h0, rv); chk(rv, 32'h0);
    av(1'b0, OFS_CONFIG, 32'h0, rv); chk(rv, 32'h0);
    av(1'b1, 5'h10, 32'hFF, rv);
    av(1'b0, 5'h10, 32'h0, rv); chk(rv, 32'h0);
    // Pin not yet a chip select: high level must not gate
    settle(6); chk({c_sel, r_sel, s_sel, m_sel}, 4'hF);
    av(1'b1, OFS_CONFIG, 32'h01, rv);
    settle(6); chk({c_sel, r_sel, s_sel, m_sel}, 4'h0);
    chk(bus, {2'b01, 4'h7});
    @(posedge clk);
    sel_req <= 4'h5;
    cs_cmd <= 1'b0;
    settle(6); chk({c_sel, r_sel, s_sel, m_sel}, 4'h5);
    @(posedge clk);
    sel_req <= 4'hA;
    settle(3); chk({c_sel, r_sel, s_sel, m_sel}, 4'hA);
    cs_cmd <= 1'b1;
    settle(6); chk({c_sel, r_sel, s_sel, m_sel}, 4'h0);
    chk(mstr, 4'h7);
    // Strobes all active, each blocked in turn from the arrays only
    strb_cmd <= 4'h8;
    for (i = 0; i < 4; i++)
    begin
      msk = 4'(1 << i);
      exp4 = (4'h8 & ~msk) | (BUS_IDLE[3:0] & msk);
      av(1'b1, OFS_PMODE2, 32'(1 << (i + 2)), rv);
      settle(2); chk(bus[3:0], exp4);
      chk(mstr, 4'h8);
    end
    av(1'b1, OFS_PMODE2, 32'h40, rv);
    settle(2); chk(bus[5:0], 6'h08);
    av(1'b1, OFS_PMODE2, 32'h00, rv);
    settle(2); chk(bus[5:0], 6'h18);
    // Common clock held high, each blocking bit in turn
    pm0_v = '{8'h00, 8'h10, 8'h20};
    clk_exp = '{3'b111, 3'b011, 3'b101};
    ck_cmd <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      av(1'b1, OFS_PMODE0, 32'(pm0_v[i]), rv);
      settle(6); chk({bus[5], mc_clk, pd_clk}, clk_exp[i]);
    end
    // Fast mode on: quiet inputs never give standby
    av(1'b1, OFS_PMODE0, 32'h00, rv);
    settle(30); chk(stby, 1'b0);
    // Fast mode off: quiet inputs give standby within the wait bound
    av(1'b1, OFS_PMODE0, 32'h08, rv);
    av(1'b0, OFS_PMODE0, 32'h0, rv); chk(rv, 32'h08);
    wait_stby(1'b1, sb); chk(sb, 1'b1);
    av(1'b0, OFS_STATUS, 32'h0, rv); chk(rv, 32'h0000_0003);
    strb_cmd <= 4'h9;
    settle(6); chk(stby, 1'b0);
    wait_stby(1'b1, sb); chk(sb, 1'b1);
    // Read strobe blocked: its edge must not wake the arrays
    av(1'b1, OFS_PMODE2, 32'h04, rv);
    wait_stby(1'b1, sb); chk(sb, 1'b1);
    strb_cmd <= 4'h8;
    settle(10); chk(stby, 1'b1);
    chk(mstr, 4'h8);
    av(1'b1, OFS_PMODE2, 32'h00, rv);
    strb_cmd <= 4'h9;
    settle(6); chk(stby, 1'b0);
    // Running clock still reaches the counter when blocked elsewhere
    av(1'b1, OFS_PMODE0, 32'h30, rv);
    ck_run <= 1'b1;
    settle(12); chk(bus[5], 1'b0);
    chk(mc_clk, 1'b0);
    sb = pd_clk;
    settle(4); chk(pd_clk, 1'(~sb));
    // Second reset clears the registers
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    av(1'b0, OFS_PMODE0, 32'h0, rv); chk(rv, 32'h0);
    wrap_up();
  end
endmodule

`default_nettype wire
